/* File: design/port_config_and_data_regs.sv */
// register file and pin control for the seven general-purpose ports
// assumes a synchronous host bus on clk_sys and logic-array terms on clk_sys
`timescale 1ns/1ns

// Functional notes
// - host reads every port register, and writes all but sample, enable status and input cells, at a fixed window offset
// - each register bit acts only on the pin of the same index
// - function, direction and driver registers clear to zero at reset
// - function select on e, f, g: zero is processor i/o, one latched address
// - without an enable term, direction one is output, zero input; input default
// - on a, b, c, f a pin drives when direction or enable term is one
// - port d direction uses only its four low bits
// - on a, b, d, e, g driver bit one selects open drain, zero push-pull
// - on c and f driver bit one selects fast edges, zero slow
// - reading the sample location returns live pin levels
// - output latch stores host data, drives enabled pins, reads back
// - output cell read returns cell outputs; write loads unblocked bits
// - block bit one stops host loads; resets to zero; readable
// - input cells on a, b, c capture pins, feed logic array, read back
// - driver enable status on a, b, c, f: one driving, zero high impedance
// - output cells and block masks on a, b only; data regs on all ports
module port_config_and_data_regs
    import port_cfg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    // host register window
    input wire logic io_window_sel,
    input wire logic host_rd,
    input wire logic host_wr,
    input wire logic [port_cfg_pkg::ADDR_W-1:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    output logic host_rdata_valid,
    // pads, one row of eight per port
    input wire logic [6:0][7:0] pin_in,
    output logic [6:0][7:0] pin_out,
    output logic [6:0][7:0] pin_oe_n,
    output logic [6:0][7:0] pin_fast_slew,
    // logic-array side
    input wire logic [6:0][7:0] logic_array_oe,
    input wire logic [6:0][7:0] logic_array_route,
    input wire logic [6:0][7:0] logic_array_data,
    input wire logic [1:0] output_macrocell_clk_en,
    input wire logic [1:0][7:0] output_macrocell_d,
    input wire logic [2:0] input_macrocell_capture,
    output logic [2:0][7:0] input_macrocell_q,
    output logic [1:0][7:0] output_macrocell_q,
    input wire logic [15:0] latched_address
);
    // register state
    logic [6:0][7:0] function_select_reg;
    logic [6:0][7:0] function_select_next;
    logic [6:0][7:0] direction_select_reg;
    logic [6:0][7:0] direction_select_next;
    logic [6:0][7:0] driver_config_reg;
    logic [6:0][7:0] driver_config_next;
    logic [6:0][7:0] output_latch_reg;
    logic [6:0][7:0] output_latch_next;
    logic [1:0][7:0] output_cell_reg;
    logic [1:0][7:0] output_cell_next;
    logic [1:0][7:0] cell_load_block_reg;
    logic [1:0][7:0] cell_load_block_next;
    logic [2:0][7:0] input_cell_reg;
    logic [2:0][7:0] input_cell_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;

    // decoded access
    logic [3:0] acc_type;
    logic [2:0] acc_port;
    logic acc_hit;
    logic wr_hit;

    // pin drive terms
    logic [6:0][7:0] drive_en;
    logic [6:0][7:0] drive_val;
    logic [6:0][7:0] open_drain;
    logic [6:0][7:0] pin_level;

    // live bits of a port
    function automatic logic [7:0] port_mask(input int unsigned p);
        if (p == PORT_D) begin
            return PORT_D_MASK;
        end
        return FULL_MASK;
    endfunction

    // does port p carry a register kind given by its presence mask
    function automatic logic port_has(input logic [6:0] has, input int unsigned p);
        return has[p];
    endfunction

    // address split: upper bits pick the kind, low three the port
    always_comb begin
        acc_type = 4'(host_addr / ADDR_W'(REG_STRIDE));
        acc_port = 3'(host_addr % ADDR_W'(REG_STRIDE));
        acc_hit = io_window_sel && (acc_type <= RT_LAST) && (acc_port < 3'(NUM_PORTS));
        wr_hit = acc_hit && host_wr;
    end

    // host writes to configuration and output latch registers
    always_comb begin
        function_select_next = function_select_reg;
        direction_select_next = direction_select_reg;
        driver_config_next = driver_config_reg;
        output_latch_next = output_latch_reg;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (wr_hit && acc_port == 3'(p)) begin
                case (acc_type)
                    RT_FUNCTION_SELECT: begin
                        if (port_has(HAS_FUNCTION_SELECT, p)) begin
                            function_select_next[p] = host_wdata;
                        end
                    end
                    RT_DIRECTION_SELECT: begin
                        direction_select_next[p] = host_wdata & port_mask(p);
                    end
                    RT_DRIVER_CONFIG: begin
                        driver_config_next[p] = host_wdata & port_mask(p);
                    end
                    RT_OUTPUT_LATCH: begin
                        output_latch_next[p] = host_wdata & port_mask(p);
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // output macrocells: logic-array clocking, host loads gated by block mask
    always_comb begin
        output_cell_next = output_cell_reg;
        cell_load_block_next = cell_load_block_reg;
        for (int p = 0; p < 2; p++) begin
            if (output_macrocell_clk_en[p]) begin
                output_cell_next[p] = output_macrocell_d[p];
            end
            if (wr_hit && acc_port == 3'(p) && port_has(HAS_OUTPUT_CELL, p)) begin
                if (acc_type == RT_OUTPUT_CELL) begin
                    // host load wins over the logic array on unblocked bits
                    output_cell_next[p] = (host_wdata & ~cell_load_block_reg[p]) |
                        (output_cell_next[p] & cell_load_block_reg[p]);
                end
                if (acc_type == RT_CELL_LOAD_BLOCK) begin
                    cell_load_block_next[p] = host_wdata;
                end
            end
        end
    end

    // input macrocells capture the synchronised pin levels on strobe
    always_comb begin
        input_cell_next = input_cell_reg;
        for (int p = 0; p < 3; p++) begin
            if (input_macrocell_capture[p]) begin
                input_cell_next[p] = pin_level[p];
            end
        end
    end

    // pin drive enable, value and driver type per port
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            // oe term only exists on a, b, c, f
            if (port_has(HAS_OE_TERM, p)) begin
                drive_en[p] = direction_select_reg[p] | logic_array_oe[p];
            end else begin
                drive_en[p] = direction_select_reg[p];
            end
            drive_en[p] = drive_en[p] & port_mask(p);
            // processor i/o default source is the output latch
            drive_val[p] = output_latch_reg[p];
            if (p == PORT_A || p == PORT_B) begin
                drive_val[p] = (output_cell_reg[p[0]] & logic_array_route[p]) |
                    (output_latch_reg[p] & ~logic_array_route[p]);
            end else if (p == PORT_C || p == PORT_F) begin
                drive_val[p] = (logic_array_data[p] & logic_array_route[p]) |
                    (drive_val[p] & ~logic_array_route[p]);
            end
            // latched address replaces the latch where function bit is one
            if (p == PORT_E || p == PORT_F) begin
                drive_val[p] = (latched_address[7:0] & function_select_reg[p]) |
                    (drive_val[p] & ~function_select_reg[p]);
            end else if (p == PORT_G) begin
                drive_val[p] = (latched_address[15:8] & function_select_reg[p]) |
                    (drive_val[p] & ~function_select_reg[p]);
            end
            // slew ports never go open drain
            if (port_has(HAS_SLEW_SELECT, p)) begin
                open_drain[p] = REG_RESET;
                pin_fast_slew[p] = driver_config_reg[p];
            end else begin
                open_drain[p] = driver_config_reg[p];
                pin_fast_slew[p] = REG_RESET;
            end
        end
    end

    // read mux; missing registers and unmapped offsets read zero
    always_comb begin
        rdata_next = READ_ZERO;
        rvalid_next = io_window_sel && host_rd;
        if (acc_hit && host_rd) begin
            case (acc_type)
                RT_LEVEL_SAMPLE: begin
                    rdata_next = pin_level[acc_port] & port_mask(acc_port);
                end
                RT_OUTPUT_LATCH: begin
                    rdata_next = output_latch_reg[acc_port];
                end
                RT_FUNCTION_SELECT: begin
                    rdata_next = function_select_reg[acc_port];
                end
                RT_DIRECTION_SELECT: begin
                    rdata_next = direction_select_reg[acc_port];
                end
                RT_DRIVER_CONFIG: begin
                    rdata_next = driver_config_reg[acc_port];
                end
                RT_DRIVER_ENABLE: begin
                    if (port_has(HAS_OE_TERM, acc_port)) begin
                        rdata_next = drive_en[acc_port];
                    end
                end
                RT_OUTPUT_CELL: begin
                    if (port_has(HAS_OUTPUT_CELL, acc_port)) begin
                        rdata_next = output_cell_reg[acc_port[0]];
                    end
                end
                RT_CELL_LOAD_BLOCK: begin
                    if (port_has(HAS_OUTPUT_CELL, acc_port)) begin
                        rdata_next = cell_load_block_reg[acc_port[0]];
                    end
                end
                RT_INPUT_CELL: begin
                    if (port_has(HAS_INPUT_CELL, acc_port)) begin
                        rdata_next = input_cell_reg[acc_port[1:0]];
                    end
                end
                default: begin
                    rdata_next = READ_ZERO;
                end
            endcase
        end
    end

    // register all state; configuration clears at reset
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            function_select_reg <= '0;
            direction_select_reg <= '0;
            driver_config_reg <= '0;
            output_latch_reg <= '0;
            output_cell_reg <= '0;
            cell_load_block_reg <= '0;
            input_cell_reg <= '0;
            rdata_reg <= REG_RESET;
            rvalid_reg <= 1'b0;
        end else begin
            function_select_reg <= function_select_next;
            direction_select_reg <= direction_select_next;
            driver_config_reg <= driver_config_next;
            output_latch_reg <= output_latch_next;
            output_cell_reg <= output_cell_next;
            cell_load_block_reg <= cell_load_block_next;
            input_cell_reg <= input_cell_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // one pin stage per port
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        port_pin_stage u_stage (
            .clk_sys(clk_sys),
            .resetn(resetn),
            .pin_in(pin_in[p]),
            .drive_en(drive_en[p]),
            .drive_val(drive_val[p]),
            .open_drain(open_drain[p]),
            .pin_out(pin_out[p]),
            .pin_oe_n(pin_oe_n[p]),
            .pin_level(pin_level[p])
        );
    end

    // host and logic-array outputs
    assign host_rdata = rdata_reg;
    assign host_rdata_valid = rvalid_reg;
    assign output_macrocell_q = output_cell_reg;
    assign input_macrocell_q = input_cell_reg;
endmodule

/* File: design/port_pin_stage.sv */
// one port's pin stage: input synchroniser and registered pad drive
// assumes pins come from outside the clock domain; drive terms from same clock
`timescale 1ns/1ns
module port_pin_stage
    import port_cfg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [PORT_W-1:0] pin_in,
    input wire logic [PORT_W-1:0] drive_en,
    input wire logic [PORT_W-1:0] drive_val,
    input wire logic [PORT_W-1:0] open_drain,
    output logic [PORT_W-1:0] pin_out,
    output logic [PORT_W-1:0] pin_oe_n,
    output logic [PORT_W-1:0] pin_level
);
    logic [PORT_W-1:0] sync1_reg;
    logic [PORT_W-1:0] sync2_reg;
    logic [PORT_W-1:0] out_reg;
    logic [PORT_W-1:0] out_next;
    logic [PORT_W-1:0] oe_n_reg;
    logic [PORT_W-1:0] oe_n_next;

    // push-pull drives both levels, open drain only pulls low
    always_comb begin
        out_next = drive_val & ~open_drain;
        oe_n_next = ~(drive_en & (~open_drain | ~drive_val));
    end

    // two-flop input synchroniser and pad output flops
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            sync1_reg <= REG_RESET;
            sync2_reg <= REG_RESET;
            out_reg <= REG_RESET;
            oe_n_reg <= FULL_MASK;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            out_reg <= out_next;
            oe_n_reg <= oe_n_next;
        end
    end

    assign pin_out = out_reg;
    assign pin_oe_n = oe_n_reg;
    assign pin_level = sync2_reg;
endmodule

/* File: include/port_cfg_pkg.sv */
// shared constants for the port configuration and data register block
// assumes a byte-wide host register window with seven-bit register offsets
package port_cfg_pkg;

    // port count and width
    localparam int unsigned NUM_PORTS = 7;
    localparam int unsigned PORT_W = 8;
    localparam int unsigned ADDR_W = 7;

    // port indices
    localparam int unsigned PORT_A = 0;
    localparam int unsigned PORT_B = 1;
    localparam int unsigned PORT_C = 2;
    localparam int unsigned PORT_D = 3;
    localparam int unsigned PORT_E = 4;
    localparam int unsigned PORT_F = 5;
    localparam int unsigned PORT_G = 6;

    // register offset = type code * REG_STRIDE + port index
    localparam int unsigned REG_STRIDE = 8;
    localparam logic [3:0] RT_LEVEL_SAMPLE = 4'h0;
    localparam logic [3:0] RT_OUTPUT_LATCH = 4'h1;
    localparam logic [3:0] RT_FUNCTION_SELECT = 4'h2;
    localparam logic [3:0] RT_DIRECTION_SELECT = 4'h3;
    localparam logic [3:0] RT_DRIVER_CONFIG = 4'h4;
    localparam logic [3:0] RT_DRIVER_ENABLE = 4'h5;
    localparam logic [3:0] RT_OUTPUT_CELL = 4'h6;
    localparam logic [3:0] RT_CELL_LOAD_BLOCK = 4'h7;
    localparam logic [3:0] RT_INPUT_CELL = 4'h8;
    localparam logic [3:0] RT_LAST = 4'h8;

    // which ports carry each register kind, bit n = port n
    localparam logic [6:0] HAS_FUNCTION_SELECT = 7'h70;
    localparam logic [6:0] HAS_OUTPUT_CELL = 7'h03;
    localparam logic [6:0] HAS_INPUT_CELL = 7'h07;
    localparam logic [6:0] HAS_OE_TERM = 7'h27;
    localparam logic [6:0] HAS_SLEW_SELECT = 7'h24;
    localparam logic [6:0] HAS_ALL = 7'h7f;

    // live bits of each port, port d has four pins
    localparam logic [7:0] FULL_MASK = 8'hff;
    localparam logic [7:0] PORT_D_MASK = 8'h0f;

    // power-up value of every writable register
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

endpackage

/* File: test/pad_world.sv */
// board model of the pads: pull-ups on every pin plus outside drivers
// assumes active-low pad enables; the block wins where it drives
`timescale 1ns/1ns
module pad_world
(
    input wire logic [6:0][7:0] pin_out,
    input wire logic [6:0][7:0] pin_oe_n,
    input wire logic [6:0][7:0] ext_en,
    input wire logic [6:0][7:0] ext_val,
    output logic [6:0][7:0] pin_in
);
    // block drive, else outside source, else pull-up level
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
        | (pin_oe_n & ~ext_en);
endmodule

/* File: test/port_regs_properties.sv */
// concurrent checks on the host window, pad outputs and input cells of the port block
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ns
module port_regs_properties
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic io_window_sel,
    input wire logic host_rd,
    input wire logic [7:0] host_rdata,
    input wire logic host_rdata_valid,
    input wire logic [6:0][7:0] pin_out,
    input wire logic [6:0][7:0] pin_oe_n,
    input wire logic [6:0][7:0] pin_fast_slew,
    input wire logic [6:0][7:0] logic_array_oe,
    input wire logic [2:0] input_macrocell_capture,
    input wire logic [2:0][7:0] input_macrocell_q
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    // read request and the port c enable term, for the past-value checks
    logic rd_req;
    logic [7:0] oe_c;
    assign rd_req = io_window_sel && host_rd;
    assign oe_c = logic_array_oe[2];

    a_read_answer: assert property (rd_req |=> host_rdata_valid)
        else $error("read not answered one cycle later");
    a_valid_cause: assert property (host_rdata_valid |-> $past(rd_req))
        else $error("read data valid without a read");
    a_idle_rdata: assert property (!host_rdata_valid |-> host_rdata == 8'h00)
        else $error("read data not zero between reads");
    a_reset_quiet: assert property ($rose(resetn) |->
        pin_oe_n == '1 && pin_out == '0 && !host_rdata_valid)
        else $error("pads driven after reset");
    a_slew_ports: assert property ((pin_fast_slew[0] | pin_fast_slew[1] |
        pin_fast_slew[3] | pin_fast_slew[4] | pin_fast_slew[6]) == 8'h00)
        else $error("fast edges on a port without slew control");
    a_oe_term_c: assert property ($past(resetn) |-> (($past(oe_c) & pin_oe_n[2]) == 8'h00))
        else $error("port c enable term did not drive the pin");
    a_port_d_upper: assert property (pin_oe_n[3][7:4] == 4'hf)
        else $error("missing port d pin driven");
    a_imc_hold: assert property (!input_macrocell_capture[1] |=>
        $stable(input_macrocell_q[1]))
        else $error("input cell changed without capture");
endmodule

bind port_config_and_data_regs port_regs_properties port_regs_properties_inst (
    .clk_sys(clk_sys), .resetn(resetn), .io_window_sel(io_window_sel), .host_rd(host_rd),
    .host_rdata(host_rdata), .host_rdata_valid(host_rdata_valid), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_fast_slew(pin_fast_slew), .logic_array_oe(logic_array_oe),
    .input_macrocell_capture(input_macrocell_capture), .input_macrocell_q(input_macrocell_q));

/* File: test/tb.sv */
// self-checking bench for the seven-port register block
// assumes pad_world on the pins and the property checker bound to the block
`timescale 1ns/1ns
module tb;
    import port_cfg_pkg::*;
    logic clk_sys, resetn, sel, rd, wr, rvalid;
    logic [6:0] addr;
    logic [7:0] wdata, rdata;
    logic [6:0][7:0] pin_in, pin_out, oe_n, slew, la_oe, la_route, la_data, ext_en, ext_val;
    logic [1:0] omc_en;
    logic [1:0][7:0] omc_d, omc_q;
    logic [2:0] imc_cap;
    logic [2:0][7:0] imc_q;
    logic [15:0] lat_addr;
    int n_fail, n_checks;

    // block under test and the board around its pins
    port_config_and_data_regs port_config_and_data_regs_inst (
        .clk_sys(clk_sys), .resetn(resetn), .io_window_sel(sel), .host_rd(rd),
        .host_wr(wr), .host_addr(addr), .host_wdata(wdata), .host_rdata(rdata),
        .host_rdata_valid(rvalid), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(oe_n),
        .pin_fast_slew(slew), .logic_array_oe(la_oe), .logic_array_route(la_route),
        .logic_array_data(la_data), .output_macrocell_clk_en(omc_en),
        .output_macrocell_d(omc_d), .input_macrocell_capture(imc_cap),
        .input_macrocell_q(imc_q), .output_macrocell_q(omc_q), .latched_address(lat_addr));
    pad_world pad_world_inst (.pin_out(pin_out), .pin_oe_n(oe_n), .ext_en(ext_en),
        .ext_val(ext_val), .pin_in(pin_in));

    // 250 mhz clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // one host write, strobe held over one rising edge
    task automatic wreg(input logic [3:0] t, input int p, input logic [7:0] d);
        {sel, wr} = 2'b11;
        addr = {t, 3'(p)};
        wdata = d;
        cyc(1);
        {sel, wr} = 2'b00;
        cyc(1);
    endtask

    // one host read, compared when the valid pulse shows
    task automatic rchk(input logic [3:0] t, input int p, input logic [7:0] e);
        {sel, rd} = 2'b11;
        addr = {t, 3'(p)};
        cyc(1);
        {sel, rd} = 2'b00;
        for (int i = 0; i < 3 && rvalid !== 1'b1; i++) cyc(1);
        if (rvalid !== 1'b1) begin
            n_fail++;
            $display("mismatch at %0t: read valid never came", $time);
        end
        chk(rdata, e);
        cyc(1);
    endtask

    task automatic reset_values();
        for (int p = 0; p < 7; p++) begin
            rchk(RT_FUNCTION_SELECT, p, 8'h00);
            rchk(RT_DIRECTION_SELECT, p, 8'h00);
            rchk(RT_DRIVER_CONFIG, p, 8'h00);
            chk(oe_n[p], 8'hff);
        end
        rchk(RT_CELL_LOAD_BLOCK, PORT_A, 8'h00);
        rchk(RT_CELL_LOAD_BLOCK, PORT_B, 8'h00);
        $display("test reset values done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // watchdog: the tests need about 240 cycles, allow 25 times that
    initial begin
        #24000;
        n_fail++;
        $display("watchdog expired");
        tally_and_finish();
    end

    initial begin
        {sel, rd, wr, addr, wdata, la_oe, la_route, la_data, ext_en, ext_val} = '0;
        {omc_en, omc_d, imc_cap, lat_addr} = '0;
        n_fail = 0;
        n_checks = 0;
        resetn = 1'b0;
        cyc(16);
        resetn = 1'b1;
        reset_values();
        // direction, enable terms and live levels
        wreg(RT_DIRECTION_SELECT, PORT_A, 8'h07);
        wreg(RT_OUTPUT_LATCH, PORT_A, 8'ha5);
        la_oe[PORT_C] = 8'h30;
        la_oe[PORT_D] = 8'hff;
        wreg(RT_DIRECTION_SELECT, PORT_C, 8'h01);
        wreg(RT_DIRECTION_SELECT, PORT_D, 8'hff);
        wreg(RT_DRIVER_CONFIG, PORT_D, 8'hff);
        cyc(4);
        chk(oe_n[PORT_A], 8'hf8);
        chk(pin_out[PORT_A] & 8'h07, 8'h05);
        chk(oe_n[PORT_C], 8'hce);
        chk(oe_n[PORT_D], 8'hf0);
        rchk(RT_DRIVER_ENABLE, PORT_C, 8'h31);
        rchk(RT_DRIVER_ENABLE, PORT_D, 8'h00);
        rchk(RT_OUTPUT_LATCH, PORT_A, 8'ha5);
        rchk(RT_LEVEL_SAMPLE, PORT_A, 8'hfd);
        rchk(RT_DIRECTION_SELECT, PORT_D, 8'h0f);
        rchk(4'h9, PORT_A, 8'h00);
        la_oe[PORT_D] = 8'h00;
        $display("test direction done");
        // driver type and edge rate on every port
        for (int p = 0; p < 7; p++) begin
            wreg(RT_DRIVER_CONFIG, p, 8'hff);
            rchk(RT_DRIVER_CONFIG, p, (p == PORT_D) ? 8'h0f : 8'hff);
            chk(slew[p], (p == PORT_C || p == PORT_F) ? 8'hff : 8'h00);
        end
        wreg(RT_DIRECTION_SELECT, PORT_A, 8'hff);
        wreg(RT_OUTPUT_LATCH, PORT_A, 8'h0f);
        ext_en[PORT_G] = 8'hff;
        ext_val[PORT_G] = 8'h3c;
        cyc(4);
        chk(oe_n[PORT_A], 8'h0f);
        rchk(RT_LEVEL_SAMPLE, PORT_A, 8'h0f);
        rchk(RT_DRIVER_ENABLE, PORT_A, 8'hff);
        rchk(RT_LEVEL_SAMPLE, PORT_G, 8'h3c);
        $display("test driver done");
        // input and output cells
        ext_en[PORT_B] = 8'hff;
        ext_val[PORT_B] = 8'h5a;
        cyc(3);
        imc_cap[PORT_B] = 1'b1;
        cyc(1);
        imc_cap[PORT_B] = 1'b0;
        cyc(2);
        chk(imc_q[PORT_B], 8'h5a);
        rchk(RT_INPUT_CELL, PORT_B, 8'h5a);
        wreg(RT_CELL_LOAD_BLOCK, PORT_A, 8'hf0);
        rchk(RT_CELL_LOAD_BLOCK, PORT_A, 8'hf0);
        wreg(RT_OUTPUT_CELL, PORT_A, 8'hff);
        chk(omc_q[PORT_A], 8'h0f);
        rchk(RT_OUTPUT_CELL, PORT_A, 8'h0f);
        omc_d[PORT_A] = 8'hc3;
        omc_en[PORT_A] = 1'b1;
        cyc(1);
        omc_en[PORT_A] = 1'b0;
        chk(omc_q[PORT_A], 8'hc3);
        wreg(RT_OUTPUT_CELL, PORT_A, 8'h00);
        chk(omc_q[PORT_A], 8'hc0);
        // upper nibble routed from the cell, lower from the latch, open drain
        la_route[PORT_A] = 8'hf0;
        cyc(4);
        chk(oe_n[PORT_A], 8'hcf);
        rchk(RT_LEVEL_SAMPLE, PORT_A, 8'hcf);
        rchk(RT_OUTPUT_CELL, PORT_C, 8'h00);
        $display("test cells done");
        // second reset, then latched address output
        resetn = 1'b0;
        la_oe[PORT_C] = 8'h00;
        cyc(16);
        resetn = 1'b1;
        reset_values();
        lat_addr = 16'h12c3;
        wreg(RT_FUNCTION_SELECT, PORT_E, 8'hff);
        wreg(RT_DIRECTION_SELECT, PORT_E, 8'hff);
        wreg(RT_FUNCTION_SELECT, PORT_G, 8'hf0);
        wreg(RT_DIRECTION_SELECT, PORT_G, 8'hff);
        wreg(RT_OUTPUT_LATCH, PORT_G, 8'h05);
        wreg(RT_FUNCTION_SELECT, PORT_A, 8'hff);
        cyc(4);
        chk(pin_out[PORT_E], 8'hc3);
        chk(pin_out[PORT_G], 8'h15);
        rchk(RT_FUNCTION_SELECT, PORT_A, 8'h00);
        rchk(RT_FUNCTION_SELECT, PORT_G, 8'hf0);
        $display("test address output done");
        tally_and_finish();
    end
endmodule
